// *** rtl/ufc_pkg.sv ***
// Shared constants for the UART flow control and line configuration block
package ufc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_EFR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_TCR = 3'h6;
    localparam logic [2:0] OFS_XON1 = 3'h4;
    localparam logic [2:0] OFS_XON2 = 3'h5;
    localparam logic [2:0] OFS_XOFF1 = 3'h6;
    localparam logic [2:0] OFS_XOFF2 = 3'h7;
    // ==========================================================
    // Reset values and keys
    localparam logic [7:0] LCR_RESET = 8'h1D;
    localparam logic [7:0] EFR_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TCR_RESET = 8'hC4;
    localparam logic [7:0] EFR_KEY = 8'hBF;
    // ==========================================================
    // Field positions
    localparam int EFR_AUTO_CTS = 7;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_SPECIAL = 5;
    localparam int EFR_ENHANCED = 4;
    localparam int LCR_DLAB = 7;
    localparam int LCR_BREAK = 6;
    localparam int SFR_EFR_LOCK = 2;
    localparam int MCR_TCR_SEL = 2;
    localparam int MCR_RTS = 1;
    localparam int IER_SLEEP = 4;
    // ==========================================================
    // Masks of bits guarded by the enhanced enable
    localparam logic [7:0] IER_ENH_MASK = 8'hF0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
    // ==========================================================
    // Interrupt source codes, bits 5:0
    localparam logic [5:0] IIR_NONE = 6'h01;
    localparam logic [5:0] IIR_SPECIAL = 6'h10;
    localparam logic [5:0] IIR_RX_DATA = 6'h04;
    localparam logic [5:0] IIR_THR = 6'h02;
    // ==========================================================
    // Flow select encodings
    localparam logic [1:0] FLOW_NONE = 2'b00;
    localparam logic [1:0] FLOW_SET1 = 2'b10;
    localparam logic [1:0] FLOW_SET2 = 2'b01;
    localparam logic [1:0] FLOW_BOTH = 2'b11;
endpackage

// *** rtl/ufc_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [CW-1:0] count_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign in_ready_out = (count_q != CW'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rd_ptr_q];
    assign count_out = count_q;

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    chk_fifo_no_over: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        count_q <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// *** rtl/ufc_core.sv ***
// UART channel flow control, enhanced feature and line control logic
// Contract
// - Enhanced feature register reachable only when line control is BF and lock bit clear.
// - Enhanced bit 7 enables automatic clear-to-send gating of transmit data.
// - Enhanced bit 6 enables automatic request-to-send from receive FIFO level.
// - Special detect stores a second-Xoff match and flags interrupt code bit 4 while enhanced bit 4 is on.
// - If receive compares second Xoff, match is dropped and raises special; it raises Xoff on its own except under select 1111 or 0011.
// - Enhanced bits of INTERRUPT_ENABLE_MASK, FIFO_SETUP_CTRL, MODEM_LINE_CTRL, thresholds writable only with bit 4.
// - Select bits 3:2 choose transmitted flow characters: none, pair 1, 2, both.
// - Select bits 1:0 choose receive comparison: none, pair 1, pair 2.
// - Select 1011 or 0111: either Xon resumes, either Xoff halts on receive.
// - Select 1111 or 0011: receive needs first then second character to act.
// - Line control register resets to 1D.
// - Line control bit 7 maps low offsets to the divisor latch unless line control is BF.
// - Line control bit 6 holds transmit pin low for break.
// - Normal low registers reachable only while line control bit 7 is zero.
`timescale 1ns/1ps
module ufc_core
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int CW = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic [7:0] special_function_ctrl_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    output logic rx_ready_out,
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    input wire logic tx_ready_in,
    input wire logic tx_serial_in,
    output logic tx_pin_out,
    input wire logic cts_n_in,
    output logic rts_n_out,
    output logic [15:0] divisor_out,
    output logic sleep_out
);
    // ==========================================================
    // Registers
    logic [7:0] efr_q;
    logic [7:0] lcr_q;
    logic [7:0] ier_q;
    logic [7:0] fcr_q;
    logic [7:0] mcr_q;
    logic [7:0] tcr_q;
    logic [7:0] dll_q;
    logic [7:0] dlm_q;
    logic [7:0] xon1_q;
    logic [7:0] xon2_q;
    logic [7:0] xoff1_q;
    logic [7:0] xoff2_q;
    logic [7:0] thr_q;
    logic thr_valid_q;
    logic [7:0] rdata_q;
    logic efr_open;
    logic key_open;
    logic normal_open;
    logic dl_open;
    logic enh;

    assign key_open = (lcr_q == EFR_KEY);
    assign efr_open = key_open && !special_function_ctrl_in[SFR_EFR_LOCK];
    assign dl_open = lcr_q[LCR_DLAB] && !key_open;
    assign normal_open = !lcr_q[LCR_DLAB];
    assign enh = efr_q[EFR_ENHANCED];

    // ==========================================================
    // Receive FIFO
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [7:0] fifo_out_data;
    logic [CW-1:0] fifo_count;

    ufc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_fifo (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(rx_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data),
        .count_out(fifo_count)
    );

    // ==========================================================
    // Receive flow character comparison
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic m_on1, m_on2, m_off1, m_off2;
    logic cmp_any;
    logic is_flow;
    logic act_on, act_off;
    logic xoff2_cmp;
    logic pend_on_q, pend_off_q;
    logic remote_halt_q;
    logic special_q;
    logic rx_take;
    logic iir_read;

    assign tx_sel = efr_q[3:2];
    assign rx_sel = efr_q[1:0];
    assign m_on1 = (rx_data_in == xon1_q);
    assign m_on2 = (rx_data_in == xon2_q);
    assign m_off1 = (rx_data_in == xoff1_q);
    assign m_off2 = (rx_data_in == xoff2_q);
    // Either-pair compare applies when one pair transmits singly with rx 11
    assign cmp_any = (rx_sel == FLOW_BOTH) && (tx_sel == FLOW_SET1 || tx_sel == FLOW_SET2);

    always_comb begin
        is_flow = 1'b0;
        act_on = 1'b0;
        act_off = 1'b0;
        xoff2_cmp = 1'b0;
        case (rx_sel)
            FLOW_SET1: begin
                is_flow = m_on1 || m_off1;
                act_on = m_on1;
                act_off = m_off1;
            end
            FLOW_SET2: begin
                is_flow = m_on2 || m_off2;
                act_on = m_on2;
                act_off = m_off2;
                xoff2_cmp = 1'b1;
            end
            FLOW_BOTH: begin
                xoff2_cmp = 1'b1;
                if (cmp_any) begin
                    is_flow = m_on1 || m_on2 || m_off1 || m_off2;
                    act_on = m_on1 || m_on2;
                    act_off = m_off1 || m_off2;
                end else begin
                    is_flow = m_on1 || m_on2 || m_off1 || m_off2;
                    act_on = pend_on_q && m_on2;
                    act_off = pend_off_q && m_off2;
                end
            end
            default: begin
                is_flow = 1'b0;
            end
        endcase
    end

    // Flow characters are consumed even with a full FIFO so halt always lands
    assign rx_ready_out = fifo_in_ready;
    assign rx_take = rx_valid_in && (is_flow || fifo_in_ready);
    assign fifo_in_valid = rx_valid_in && !is_flow;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_on_q <= 1'b0;
            pend_off_q <= 1'b0;
        end else if (rx_take) begin
            pend_on_q <= m_on1 && !cmp_any && (rx_sel == FLOW_BOTH);
            pend_off_q <= m_off1 && !cmp_any && (rx_sel == FLOW_BOTH);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            remote_halt_q <= 1'b0;
        end else if (rx_sel == FLOW_NONE) begin
            remote_halt_q <= 1'b0;
        end else if (rx_take && act_off) begin
            remote_halt_q <= 1'b1;
        end else if (rx_take && act_on) begin
            remote_halt_q <= 1'b0;
        end
    end

    // Set wins over the clear by an interrupt code read
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            special_q <= 1'b0;
        end else if (rx_take && efr_q[EFR_SPECIAL] && m_off2) begin
            special_q <= 1'b1;
        end else if (iir_read) begin
            special_q <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit flow character sequencer
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_CHAR_A = 3'b010,
        TX_CHAR_B = 3'b100
    } ufc_txs_t;

    ufc_txs_t txs_q;
    logic sent_off_q;
    logic send_off_q;
    logic want_off, want_on;
    logic [7:0] char_a, char_b;
    logic flow_busy;
    logic data_ok;

    assign want_off = (fifo_count >= CW'(tcr_q[3:0])) && !sent_off_q;
    assign want_on = (fifo_count <= CW'(tcr_q[7:4])) && sent_off_q;
    assign char_a = (tx_sel == FLOW_SET2) ? (send_off_q ? xoff2_q : xon2_q)
                                          : (send_off_q ? xoff1_q : xon1_q);
    assign char_b = send_off_q ? xoff2_q : xon2_q;
    assign flow_busy = (txs_q != TX_IDLE);

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            txs_q <= TX_IDLE;
            sent_off_q <= 1'b0;
            send_off_q <= 1'b0;
        end else begin
            case (txs_q)
                TX_IDLE: begin
                    if (tx_sel == FLOW_NONE) begin
                        sent_off_q <= 1'b0;
                    end else if (want_off || want_on) begin
                        send_off_q <= want_off;
                        sent_off_q <= want_off;
                        txs_q <= TX_CHAR_A;
                    end
                end
                TX_CHAR_A: begin
                    if (tx_ready_in) begin
                        txs_q <= (tx_sel == FLOW_BOTH) ? TX_CHAR_B : TX_IDLE;
                    end
                end
                TX_CHAR_B: begin
                    if (tx_ready_in) begin
                        txs_q <= TX_IDLE;
                    end
                end
                default: begin
                    txs_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Data waits for clear-to-send and for the peer's Xon; flow chars bypass both
    assign data_ok = thr_valid_q && !flow_busy && !remote_halt_q
                     && !(efr_q[EFR_AUTO_CTS] && cts_n_in);
    assign tx_valid_out = flow_busy || data_ok;
    assign tx_data_out = (txs_q == TX_CHAR_A) ? char_a :
                         (txs_q == TX_CHAR_B) ? char_b : thr_q;
    assign tx_pin_out = lcr_q[LCR_BREAK] ? 1'b0 : tx_serial_in;

    // ==========================================================
    // Request-to-send
    logic rts_hold_q;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rts_hold_q <= 1'b0;
        end else if (fifo_count >= CW'(tcr_q[3:0])) begin
            rts_hold_q <= 1'b1;
        end else if (fifo_count <= CW'(tcr_q[7:4])) begin
            rts_hold_q <= 1'b0;
        end
    end

    assign rts_n_out = efr_q[EFR_AUTO_RTS] ? rts_hold_q : !mcr_q[MCR_RTS];
    assign divisor_out = {dlm_q, dll_q};
    assign sleep_out = enh && ier_q[IER_SLEEP];

    // ==========================================================
    // Register writes
    logic wr_efr, wr_tcr, wr_thr, tcr_open;

    assign tcr_open = normal_open && mcr_q[MCR_TCR_SEL];
    assign wr_efr = wr_in && addr_in == OFS_EFR && efr_open;
    assign wr_tcr = wr_in && addr_in == OFS_TCR && tcr_open && enh;
    assign wr_thr = wr_in && addr_in == OFS_DATA && normal_open;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            efr_q <= EFR_RESET;
            lcr_q <= LCR_RESET;
            ier_q <= REG_RESET;
            fcr_q <= REG_RESET;
            mcr_q <= REG_RESET;
            tcr_q <= TCR_RESET;
            dll_q <= REG_RESET;
            dlm_q <= REG_RESET;
            xon1_q <= REG_RESET;
            xon2_q <= REG_RESET;
            xoff1_q <= REG_RESET;
            xoff2_q <= REG_RESET;
        end else if (wr_in) begin
            if (wr_efr) begin
                efr_q <= wdata_in;
            end
            if (addr_in == OFS_LCR) begin
                lcr_q <= wdata_in;
            end
            if (wr_tcr) begin
                tcr_q <= wdata_in;
            end
            if (dl_open && addr_in == OFS_DATA) begin
                dll_q <= wdata_in;
            end
            if (dl_open && addr_in == OFS_IER) begin
                dlm_q <= wdata_in;
            end
            if (key_open) begin
                case (addr_in)
                    OFS_XON1: xon1_q <= wdata_in;
                    OFS_XON2: xon2_q <= wdata_in;
                    OFS_XOFF1: xoff1_q <= wdata_in;
                    OFS_XOFF2: xoff2_q <= wdata_in;
                    default: xon1_q <= xon1_q;
                endcase
            end
            if (normal_open && addr_in == OFS_IER) begin
                ier_q <= enh ? wdata_in : ((ier_q & IER_ENH_MASK) | (wdata_in & ~IER_ENH_MASK));
            end
            if (normal_open && addr_in == OFS_EFR) begin
                fcr_q <= enh ? wdata_in : ((fcr_q & FCR_ENH_MASK) | (wdata_in & ~FCR_ENH_MASK));
            end
            if (normal_open && addr_in == OFS_MCR) begin
                mcr_q <= enh ? wdata_in : ((mcr_q & MCR_ENH_MASK) | (wdata_in & ~MCR_ENH_MASK));
            end
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            thr_q <= REG_RESET;
            thr_valid_q <= 1'b0;
        end else if (wr_thr) begin
            thr_q <= wdata_in;
            thr_valid_q <= 1'b1;
        end else if (data_ok && tx_ready_in) begin
            thr_valid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Register reads, answered one cycle after rd_in
    logic [5:0] iir_code;

    assign iir_read = rd_in && addr_in == OFS_EFR && normal_open;
    assign fifo_pop = rd_in && addr_in == OFS_DATA && normal_open && fifo_out_valid;
    // Special code only reported while enhanced functions are on
    assign iir_code = (special_q && enh) ? IIR_SPECIAL :
                      fifo_out_valid ? IIR_RX_DATA :
                      !thr_valid_q ? IIR_THR : IIR_NONE;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= REG_RESET;
        end else if (rd_in) begin
            rdata_q <= REG_RESET;
            if (efr_open && addr_in == OFS_EFR) begin
                rdata_q <= efr_q;
            end else if (addr_in == OFS_LCR) begin
                rdata_q <= lcr_q;
            end else if (key_open) begin
                case (addr_in)
                    OFS_XON1: rdata_q <= xon1_q;
                    OFS_XON2: rdata_q <= xon2_q;
                    OFS_XOFF1: rdata_q <= xoff1_q;
                    OFS_XOFF2: rdata_q <= xoff2_q;
                    default: rdata_q <= REG_RESET;
                endcase
            end else if (dl_open) begin
                rdata_q <= (addr_in == OFS_DATA) ? dll_q :
                           (addr_in == OFS_IER) ? dlm_q : REG_RESET;
            end else begin
                case (addr_in)
                    OFS_DATA: rdata_q <= fifo_out_data;
                    OFS_IER: rdata_q <= ier_q;
                    OFS_EFR: rdata_q <= {{2{fcr_q[0]}}, iir_code};
                    OFS_MCR: rdata_q <= mcr_q;
                    OFS_LSR: rdata_q <= {1'b0, !thr_valid_q, !thr_valid_q, 4'h0, fifo_out_valid};
                    OFS_TCR: rdata_q <= mcr_q[MCR_TCR_SEL] ? tcr_q : REG_RESET;
                    default: rdata_q <= REG_RESET;
                endcase
            end
        end
    end

    assign rdata_out = rdata_q;

    // ==========================================================
    // Checks
    chk_efr_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (wr_in && !efr_open && !(normal_open && addr_in == OFS_EFR)) |=> $stable(efr_q))
        else $error("enhanced register changed while locked");
    chk_cts_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (efr_q[EFR_AUTO_CTS] && cts_n_in && !flow_busy) |-> !tx_valid_out)
        else $error("data sent while clear-to-send high");
    chk_rts_auto: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (efr_q[EFR_AUTO_RTS] && fifo_count >= CW'(tcr_q[3:0])) |=> rts_n_out)
        else $error("request-to-send not deasserted at halt level");
    chk_spec_set: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (rx_take && efr_q[EFR_SPECIAL] && m_off2) |=> special_q)
        else $error("special character not flagged");
    chk_flow_drop: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (rx_valid_in && is_flow) |-> !fifo_in_valid)
        else $error("flow character written to fifo");
    chk_ier_lock: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !enh |=> (ier_q[7:4] == $past(ier_q[7:4])))
        else $error("upper enable bits changed without enhanced enable");
    chk_xoff_halt: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (rx_take && act_off && rx_sel != FLOW_NONE) |=> remote_halt_q)
        else $error("xoff did not halt transmit");
    chk_dual_need: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (rx_take && !cmp_any && rx_sel == FLOW_BOTH && m_off2 && !m_on2 && !pend_off_q)
        |=> $stable(remote_halt_q))
        else $error("lone second xoff changed transmit halt");
    chk_break_low: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        lcr_q[LCR_BREAK] |-> !tx_pin_out)
        else $error("transmit pin not held low in break");
    chk_xoff_send: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (txs_q == TX_IDLE && tx_sel != FLOW_NONE && want_off) |=> (txs_q == TX_CHAR_A && send_off_q))
        else $error("xoff not queued at halt level");
endmodule

// *** dv/ufc_peer.sv ***
// Remote serial peer model that takes transmitted characters with random stalls
`timescale 1ns/1ps
module ufc_peer (
    input wire logic clock_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    // ========================================
    // Stalls check that characters are held until taken
    initial tx_ready_out = 1'b0;
    always @(posedge clock_in) tx_ready_out <= ($urandom % 3) != 0;
endmodule

// *** dv/tb.sv ***
// Testbench for the UART flow control and line configuration block
`timescale 1ns/1ps
module tb;
    import ufc_pkg::*;
    logic clock_in = 0, reset_n_in = 0, wr = 0, rd = 0, rd_d = 0, rxv = 0, cts_n = 0, ser = 1;
    logic [2:0] a = 0;
    logic [7:0] wd = 0, rxd = 0, special_function_ctrl = 0, rdo, txd, x;
    logic rxr, txv, txr, pin, rts_n, slp;
    logic [15:0] dv;
    logic [7:0] rq[$], tq[$], r[4];
    int fails = 0, check_count = 0;
    initial forever #5 clock_in = ~clock_in;
    ufc_core i_ufc_core(.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(a), .wr_in(wr),
        .rd_in(rd), .wdata_in(wd), .rdata_out(rdo), .special_function_ctrl_in(special_function_ctrl),
        .rx_valid_in(rxv), .rx_data_in(rxd), .rx_ready_out(rxr), .tx_valid_out(txv),
        .tx_data_out(txd), .tx_ready_in(txr), .tx_serial_in(ser), .tx_pin_out(pin),
        .cts_n_in(cts_n), .rts_n_out(rts_n), .divisor_out(dv), .sleep_out(slp));
    ufc_peer i_ufc_peer(.clock_in(clock_in), .tx_valid_in(txv), .tx_ready_out(txr));
    // ========================================
    // Shared tasks
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(logic [2:0] ad, logic [7:0] d);
        @(posedge clock_in);
        a <= ad; wd <= d; wr <= 1;
        @(posedge clock_in);
        wr <= 0;
    endtask
    task automatic rreg(logic [2:0] ad, logic [7:0] e);
        @(posedge clock_in);
        a <= ad; rd <= 1; rq.push_back(e);
        @(posedge clock_in);
        rd <= 0;
    endtask
    task automatic rx(logic [7:0] d);
        @(posedge clock_in);
        rxv <= 1; rxd <= d;
        @(posedge clock_in);
        rxv <= 0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========================================
    // Result watchers: oldest note is compared when a result appears
    always @(posedge clock_in) begin
        rd_d <= rd;
        if (rd_d) chk("rdata", rdo, rq.pop_front());
        if (txv === 1'b1 && txr === 1'b1) chk("tx char", txd, tq.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        fails++;
        final_report();
    end
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'he257d37b));
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1;
        rreg(OFS_LCR, LCR_RESET);
        wreg(OFS_LCR, EFR_KEY);
        rreg(OFS_EFR, EFR_RESET);
        special_function_ctrl <= 8'h04;
        wreg(OFS_EFR, 8'hFF);
        rreg(OFS_EFR, 8'h00);
        special_function_ctrl <= 8'h00;
        wreg(OFS_EFR, 8'h1A);
        rreg(OFS_EFR, 8'h1A);
        wreg(OFS_XON1, 8'h11);
        wreg(OFS_XOFF1, 8'h13);
        wreg(OFS_LCR, 8'h80);
        wreg(OFS_DATA, 8'h34);
        wreg(OFS_IER, 8'h12);
        @(posedge clock_in);
        chk("divisor", dv, 16'h1234);
        wreg(OFS_LCR, 8'h43);
        @(posedge clock_in);
        chk("break pin", pin, 1'b0);
        rreg(OFS_IER, 8'h00);
        wreg(OFS_LCR, 8'h03);
        @(posedge clock_in);
        chk("idle pin", pin, 1'b1);
        ser <= 0;
        @(posedge clock_in);
        chk("line pin", pin, 1'b0);
        ser <= 1;
        $display("register tests done");
        wreg(OFS_MCR, 8'h06);
        wreg(OFS_TCR, 8'h24);
        rreg(OFS_TCR, 8'h24);
        wreg(OFS_IER, 8'h10);
        @(posedge clock_in);
        chk("sleep on", slp, 1'b1);
        x = 8'h40 | 8'($urandom % 32);
        cts_n <= 1;
        tq.push_back(x);
        wreg(OFS_DATA, x);
        repeat (20) @(posedge clock_in);
        wreg(OFS_LCR, EFR_KEY);
        wreg(OFS_EFR, 8'hDA);
        wreg(OFS_LCR, 8'h03);
        wreg(OFS_DATA, x + 8'h01);
        repeat (20) @(posedge clock_in);
        chk("cts hold", txv, 1'b0);
        tq.push_back(x + 8'h01);
        cts_n <= 0;
        repeat (20) @(posedge clock_in);
        rx(8'h13);
        wreg(OFS_DATA, x + 8'h02);
        repeat (20) @(posedge clock_in);
        chk("xoff hold", txv, 1'b0);
        tq.push_back(x + 8'h02);
        rx(8'h11);
        repeat (20) @(posedge clock_in);
        tq.push_back(8'h13);
        for (int i = 0; i < 4; i++) begin
            r[i] = 8'h40 | 8'($urandom % 32);
            rx(r[i]);
        end
        repeat (20) @(posedge clock_in);
        chk("rts halt", rts_n, 1'b1);
        chk("rx ready", rxr, 1'b1);
        tq.push_back(8'h11);
        for (int i = 0; i < 3; i++) rreg(OFS_DATA, r[i]);
        repeat (20) @(posedge clock_in);
        chk("rts resume", rts_n, 1'b0);
        rreg(OFS_DATA, r[3]);
        wreg(OFS_LCR, EFR_KEY);
        wreg(OFS_XON2, 8'h12);
        wreg(OFS_XOFF2, 8'h14);
        wreg(OFS_EFR, 8'h3A);
        wreg(OFS_LCR, 8'h03);
        rx(8'h14);
        rreg(OFS_EFR, 8'h10);
        rreg(OFS_DATA, 8'h14);
        wreg(OFS_LCR, EFR_KEY);
        wreg(OFS_EFR, 8'h1B);
        wreg(OFS_LCR, 8'h03);
        rx(8'h14);
        wreg(OFS_DATA, 8'h5A);
        repeat (8) @(posedge clock_in);
        chk("either xoff", txv, 1'b0);
        tq.push_back(8'h5A);
        rx(8'h12);
        repeat (8) @(posedge clock_in);
        wreg(OFS_LCR, EFR_KEY);
        wreg(OFS_EFR, 8'h33);
        wreg(OFS_LCR, 8'h03);
        tq.push_back(8'h5B);
        rx(8'h14);
        wreg(OFS_DATA, 8'h5B);
        repeat (8) @(posedge clock_in);
        rx(8'h13);
        rx(8'h14);
        wreg(OFS_DATA, 8'h5C);
        repeat (8) @(posedge clock_in);
        chk("paired xoff", txv, 1'b0);
        tq.push_back(8'h5C);
        rx(8'h11);
        rx(8'h12);
        repeat (8) @(posedge clock_in);
        rreg(OFS_LSR, 8'h60);
        rreg(OFS_EFR, 8'h10);
        rreg(OFS_EFR, 8'h02);
        wreg(OFS_LCR, EFR_KEY);
        wreg(OFS_EFR, 8'h00);
        wreg(OFS_LCR, 8'h03);
        wreg(OFS_IER, 8'h0F);
        rreg(OFS_IER, 8'h1F);
        chk("sleep off", slp, 1'b0);
        repeat (20) @(posedge clock_in);
        chk("tx notes left", 16'(tq.size()), 16'h0000);
        $display("flow tests done");
        final_report();
    end
endmodule
